// *** hdl/dtf_map.svh ***
// Register offsets, field positions and reset values of the dual timer
// flag and output control block.
// Assumes AHB-Lite byte addresses, one 32-bit word per register.
`ifndef DTF_MAP_SVH
`define DTF_MAP_SVH

`define DTF_OFF_CSC_LO 8'h00
`define DTF_OFF_CSC_HI 8'h04
`define DTF_OFF_FN_LO 8'h08
`define DTF_OFF_FN_HI 8'h0c
`define DTF_OFF_PAIR 8'h10
`define DTF_OFF_DR_LO 8'h14
`define DTF_OFF_DR_HI 8'h18
`define DTF_OFF_RMW_LO 8'h1c
`define DTF_OFF_RMW_HI 8'h20

`define DTF_CSC_RUN 7
`define DTF_CSC_SUSP 6
`define DTF_CSC_IE 5
`define DTF_CSC_BF 3
`define DTF_CSC_IF 2
`define DTF_CSC_SO 1
`define DTF_CSC_OE 0

`define DTF_FN_RIG 4

`define DTF_PC_UOUT 7
`define DTF_PC_LOUT 6
`define DTF_PC_ISEL 5
`define DTF_PC_WSEL 4
`define DTF_PC_UFLT 3:2
`define DTF_PC_LFLT 1:0

`define DTF_CSC_RST 8'h00
`define DTF_FN_RST 5'h00
`define DTF_PAIR_RST 8'h00
`define DTF_DR_RST 8'h00

`endif

// *** hdl/dtf_pkg.sv ***
// Types and mode decoding shared by the dual timer flag logic.
// Assumes nothing beyond the register map header.
package dtf_pkg;

	typedef enum logic [3:0] {
		DTF_F_ONESHOT = 4'h0,
		DTF_F_CONT = 4'h1,
		DTF_F_FREERUN = 4'h2,
		DTF_F_PWM_FIX = 4'h3,
		DTF_F_PWM_VAR = 4'h4,
		DTF_F_PWC_HI = 4'h5,
		DTF_F_PWC_LO = 4'h6,
		DTF_F_PWC_CYR = 4'h7,
		DTF_F_PWC_CYF = 4'h8,
		DTF_F_PWC_HC = 4'h9,
		DTF_F_CAP_R = 4'ha,
		DTF_F_CAP_F = 4'hb,
		DTF_F_CAP_B = 4'hc,
		DTF_F_CAPC_R = 4'hd,
		DTF_F_CAPC_F = 4'he,
		DTF_F_CAPC_B = 4'hf
	} dtf_func_e;

	typedef enum logic [1:0] {
		DTF_BUS_IDLE = 2'b00,
		DTF_BUS_WR = 2'b01,
		DTF_BUS_RD = 2'b10,
		DTF_BUS_RDOUT = 2'b11
	} dtf_bus_e;

	function automatic logic dtf_is_pwc(input logic [3:0] f);
		dtf_is_pwc = (f >= 4'h5) && (f <= 4'h9);
	endfunction : dtf_is_pwc

	function automatic logic dtf_is_cap(input logic [3:0] f);
		dtf_is_cap = (f >= 4'ha);
	endfunction : dtf_is_cap

	// Initial output value only matters for interval and pulse width
	function automatic logic dtf_so_used(input logic [3:0] f);
		dtf_so_used = (f != 4'h3) && (f != 4'h4) && !dtf_is_cap(f);
	endfunction : dtf_so_used

endpackage : dtf_pkg

// *** hdl/dtf_ahb.sv ***
// AHB-Lite slave front end: one register access per transfer.
// Assumes single word transfers; reads take one wait state.
`timescale 1ns/1ps
module dtf_ahb (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic wr_stb,
	output logic rd_stb,
	output logic [7:0] reg_addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	dtf_pkg::dtf_bus_e st_r;
	dtf_pkg::dtf_bus_e st_nxt;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r;
	wire logic take_w;

	// Only whole-word transfers are taken; other sizes pass unseen
	assign take_w = hsel && htrans[1] && hready && (hsize == 3'h2);

	always_comb begin
		unique case (st_r)
			dtf_pkg::DTF_BUS_IDLE, dtf_pkg::DTF_BUS_WR,
			dtf_pkg::DTF_BUS_RDOUT: begin
				if (take_w) begin
					st_nxt = hwrite ? dtf_pkg::DTF_BUS_WR : dtf_pkg::DTF_BUS_RD;
				end else begin
					st_nxt = dtf_pkg::DTF_BUS_IDLE;
				end
			end
			dtf_pkg::DTF_BUS_RD: begin
				st_nxt = dtf_pkg::DTF_BUS_RDOUT;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= dtf_pkg::DTF_BUS_IDLE;
			addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			if (take_w) begin
				addr_r <= haddr[7:0];
			end
			if (st_r == dtf_pkg::DTF_BUS_RD) begin
				hrdata_r <= {24'h00_0000, rdata};
			end
		end
	end

	// Wait state lets a read see a write that just landed
	assign hreadyout = (st_r != dtf_pkg::DTF_BUS_RD);
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign wr_stb = (st_r == dtf_pkg::DTF_BUS_WR);
	assign rd_stb = (st_r == dtf_pkg::DTF_BUS_RD);
	assign reg_addr = addr_r;
	assign wdata = hwdata[7:0];
endmodule : dtf_ahb

// *** hdl/dtf_chan.sv ***
// One timer channel: data-full flag, reload flag, data register and
// output state with its per-function memory.
// Assumes event inputs come from the counter datapath on hclk.
`timescale 1ns/1ps
`include "dtf_map.svh"
module dtf_chan (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] func,
	input wire logic run,
	input wire logic run_rise,
	input wire logic hold_zero,
	input wire logic out_undef,
	input wire logic so_eff,
	input wire logic meas_valid,
	input wire logic meas_cycle,
	input wire logic [7:0] meas_count,
	input wire logic match,
	input wire logic ovf,
	input wire logic fn_out,
	input wire logic dr_read,
	input wire logic dr_wr,
	input wire logic if_clr,
	input wire logic [7:0] wdata,
	output logic bf,
	output logic iflag,
	output logic out_state,
	output logic [7:0] dr
);
	logic bf_r;
	logic if_r;
	logic out_r;
	logic [7:0] dr_r;
	logic [15:0] omem_r;
	logic [3:0] func_prev_r;
	wire logic pwc_w;
	wire logic cap_w;
	wire logic store_w;
	wire logic set_if_w;
	wire logic bf_nxt;
	wire logic if_nxt;

	assign pwc_w = dtf_pkg::dtf_is_pwc(func);
	assign cap_w = dtf_pkg::dtf_is_cap(func);

	// High pulse result of the combined mode passes a full register
	assign store_w = meas_valid && pwc_w && (!bf_r ||
		(func == dtf_pkg::DTF_F_PWC_HC && !meas_cycle)); // RQ1 RQ3 RQ4

	// Set beats clear in the same cycle
	assign bf_nxt = (!pwc_w || hold_zero) ? 1'b0 : // RQ6 RQ7
		store_w ? 1'b1 : // RQ1
		dr_read ? 1'b0 : bf_r; // RQ2 RQ6

	assign set_if_w = (match && (func == dtf_pkg::DTF_F_ONESHOT ||
		func == dtf_pkg::DTF_F_CONT)) || // RQ8
		(ovf && (pwc_w || cap_w)); // RQ9

	// Forced zero in variable PWM outranks the match set
	assign if_nxt = (func == dtf_pkg::DTF_F_PWM_VAR || hold_zero) ? 1'b0 :
		set_if_w ? 1'b1 : // RQ11 RQ12
		if_clr ? 1'b0 : if_r; // RQ10

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bf_r <= 1'b0;
			if_r <= 1'b0;
		end else begin
			bf_r <= bf_nxt;
			if_r <= if_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dr_r <= `DTF_DR_RST;
		end else if (store_w || (meas_valid && cap_w)) begin
			dr_r <= meas_count; // RQ1
		end else if (dr_wr && !pwc_w && !cap_w) begin
			dr_r <= wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_r <= 1'b0;
			omem_r <= 16'h0000;
			func_prev_r <= 4'h0;
		end else begin
			func_prev_r <= func;
			if (run_rise && dtf_pkg::dtf_so_used(func)) begin
				out_r <= so_eff; // RQ13 RQ14 RQ16
			end else if (run) begin
				out_r <= fn_out; // RQ19
			end else if (func != func_prev_r) begin
				out_r <= omem_r[func]; // RQ22
			end
			if (run) begin
				omem_r[func] <= fn_out;
			end
		end
	end

	assign bf = bf_r;
	assign iflag = if_r;
	// Undefined state reads as zero
	assign out_state = out_r && !out_undef; // RQ20 RQ21
	assign dr = dr_r;
endmodule : dtf_chan

// *** hdl/dtf_top.sv ***
// Dual timer flags and output control: register file, run control,
// pin output enables and reload interrupt requests for a timer pair.
// Operation
// RQ1 - Measurement stored sets data-full flag
// RQ2 - Data register read clears flag (8-bit)
// RQ3 - Full flag blocks further stores
// RQ4 - Combined mode: high pulse still stored
// RQ5 - Software reads results before next pulse
// RQ6 - 16-bit: upper read clears lower flag
// RQ7 - Flag zero outside pulse width; writes ignored
// RQ8 - Count match sets reload flag
// RQ9 - Overflow sets reload flag when measuring
// RQ10 - Reload flag: RMW read one, write-zero clears
// RQ11 - Variable PWM forces reload flag zero
// RQ12 - 16-bit: upper reload flag held zero
// RQ13 - Start loads initial output value
// RQ14 - 16-bit: lower initial value only
// RQ15 - Initial value locked while running; code leaves upper writable in 16-bit
// RQ16 - Initial value unused in PWM, capture
// RQ17 - Enable selects timer drive or port
// RQ18 - Pair configuration layout, reset zero
// RQ19 - Upper output state read-only, follows function
// RQ20 - Upper state undefined in some 16-bit modes
// RQ21 - Stop keeps last output state
// RQ22 - Function change recalls per-function state
// RQ23 - Run bit starts and stops counting
// RQ24 - Variable PWM mirrors run and suspend
// RQ25 - Reload interrupt needs both gates
// RQ26 - Alias address marks RMW reads
// Assumes a counter datapath on hclk supplying events and output values.
`timescale 1ns/1ps
`include "dtf_map.svh"
module dtf_top #(
	parameter bit CHAN_ZERO = 1'b1
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic meas_valid_lo,
	input wire logic meas_valid_hi,
	input wire logic meas_cycle_lo,
	input wire logic meas_cycle_hi,
	input wire logic [7:0] meas_count_lo,
	input wire logic [7:0] meas_count_hi,
	input wire logic match_lo,
	input wire logic match_hi,
	input wire logic ovf_lo,
	input wire logic ovf_hi,
	input wire logic fn_out_lo,
	input wire logic fn_out_hi,
	output logic run_lo,
	output logic run_hi,
	output logic susp_lo,
	output logic susp_hi,
	output logic [3:0] func_lo,
	output logic [3:0] func_hi,
	output logic width_sel,
	output logic input_source_sel,
	output logic [1:0] upper_noise_filter_sel,
	output logic [1:0] lower_noise_filter_sel,
	output logic [7:0] lower_data_reg,
	output logic [7:0] upper_data_reg,
	output logic pin_lo_o,
	output logic pin_lo_oe,
	output logic pin_hi_o,
	output logic pin_hi_oe,
	output logic irq_lo,
	output logic irq_hi
);
	wire logic wr_stb;
	wire logic rd_stb;
	wire logic [7:0] reg_addr;
	wire logic [7:0] wdata;
	logic [7:0] rdata;

	logic run_lo_r;
	logic run_hi_r;
	logic run_lo_prev_r;
	logic run_hi_prev_r;
	logic susp_lo_r;
	logic susp_hi_r;
	logic ie_lo_r;
	logic ie_hi_r;
	logic so_lo_r;
	logic so_hi_r;
	logic oe_lo_r;
	logic oe_hi_r;
	logic [3:0] func_lo_r;
	logic [3:0] func_hi_r;
	logic rig_lo_r;
	logic rig_hi_r;
	logic isel_r;
	logic wsel_r;
	logic [1:0] uflt_r;
	logic [1:0] lflt_r;

	wire logic bf_lo;
	wire logic bf_hi;
	wire logic if_lo;
	wire logic if_hi;
	wire logic out_lo;
	wire logic out_hi;
	wire logic [7:0] dr_lo;
	wire logic [7:0] dr_hi;

	dtf_ahb u_ahb (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hwdata(hwdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.reg_addr(reg_addr),
		.wdata(wdata),
		.rdata(rdata)
	);

	// Address decode
	wire logic wr_csc_lo = wr_stb && (reg_addr == `DTF_OFF_CSC_LO);
	wire logic wr_csc_hi = wr_stb && (reg_addr == `DTF_OFF_CSC_HI);
	wire logic wr_fn_lo = wr_stb && (reg_addr == `DTF_OFF_FN_LO);
	wire logic wr_fn_hi = wr_stb && (reg_addr == `DTF_OFF_FN_HI);
	wire logic wr_pair = wr_stb && (reg_addr == `DTF_OFF_PAIR);
	wire logic wr_dr_lo = wr_stb && (reg_addr == `DTF_OFF_DR_LO);
	wire logic wr_dr_hi = wr_stb && (reg_addr == `DTF_OFF_DR_HI);
	wire logic rd_dr_lo = rd_stb && (reg_addr == `DTF_OFF_DR_LO);
	wire logic rd_dr_hi = rd_stb && (reg_addr == `DTF_OFF_DR_HI);

	// Both run bits move together in variable PWM or 16-bit mode
	wire logic mirror_w = wsel_r ||
		(func_lo_r == dtf_pkg::DTF_F_PWM_VAR); // RQ24
	wire logic any_run_w = run_lo_r || run_hi_r;

	wire logic run_lo_nxt = wr_csc_lo ? wdata[`DTF_CSC_RUN] :
		(wr_csc_hi && mirror_w) ? wdata[`DTF_CSC_RUN] : run_lo_r; // RQ23
	wire logic run_hi_nxt = wr_csc_hi ? wdata[`DTF_CSC_RUN] :
		(wr_csc_lo && mirror_w) ? wdata[`DTF_CSC_RUN] : run_hi_r; // RQ24
	wire logic susp_lo_nxt = wr_csc_lo ? wdata[`DTF_CSC_SUSP] :
		(wr_csc_hi && mirror_w) ? wdata[`DTF_CSC_SUSP] : susp_lo_r;
	wire logic susp_hi_nxt = wr_csc_hi ? wdata[`DTF_CSC_SUSP] :
		(wr_csc_lo && mirror_w) ? wdata[`DTF_CSC_SUSP] : susp_hi_r;

	// Initial value locked while running; upper stays writable in 16-bit
	wire logic so_lo_we = wr_csc_lo && !run_lo_r; // RQ15
	wire logic so_hi_we = wr_csc_hi && (!run_hi_r || wsel_r); // RQ15

	wire logic run_lo_rise = run_lo_r && !run_lo_prev_r;
	wire logic run_hi_rise = run_hi_r && !run_hi_prev_r;

	// 16-bit start in variable PWM drops back to 8-bit
	wire logic wsel_drop_w = run_lo_rise &&
		(func_lo_r == dtf_pkg::DTF_F_PWM_VAR);
	wire logic pair_we = wr_pair && !any_run_w;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_lo_r <= 1'b0;
			run_hi_r <= 1'b0;
			run_lo_prev_r <= 1'b0;
			run_hi_prev_r <= 1'b0;
			susp_lo_r <= 1'b0;
			susp_hi_r <= 1'b0;
		end else begin
			run_lo_r <= run_lo_nxt;
			run_hi_r <= run_hi_nxt;
			run_lo_prev_r <= run_lo_r;
			run_hi_prev_r <= run_hi_r;
			susp_lo_r <= susp_lo_nxt;
			susp_hi_r <= susp_hi_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ie_lo_r <= 1'b0;
			ie_hi_r <= 1'b0;
			oe_lo_r <= 1'b0;
			oe_hi_r <= 1'b0;
		end else begin
			if (wr_csc_lo) begin
				ie_lo_r <= wdata[`DTF_CSC_IE];
				oe_lo_r <= wdata[`DTF_CSC_OE];
			end
			if (wr_csc_hi) begin
				ie_hi_r <= wdata[`DTF_CSC_IE];
				oe_hi_r <= wdata[`DTF_CSC_OE];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			so_lo_r <= 1'b0;
			so_hi_r <= 1'b0;
		end else begin
			if (so_lo_we) begin
				so_lo_r <= wdata[`DTF_CSC_SO]; // RQ15
			end
			if (so_hi_we) begin
				so_hi_r <= wdata[`DTF_CSC_SO]; // RQ15
			end
		end
	end

	// Function select is frozen while its timer runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			func_lo_r <= 4'h0;
			func_hi_r <= 4'h0;
			rig_lo_r <= 1'b0;
			rig_hi_r <= 1'b0;
		end else begin
			if (wr_fn_lo) begin
				rig_lo_r <= wdata[`DTF_FN_RIG];
				if (!run_lo_r) begin
					func_lo_r <= wdata[3:0];
				end
			end
			if (wr_fn_hi) begin
				rig_hi_r <= wdata[`DTF_FN_RIG];
				if (!run_hi_r) begin
					func_hi_r <= wdata[3:0];
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			isel_r <= 1'b0;
			wsel_r <= 1'b0;
			uflt_r <= 2'h0;
			lflt_r <= 2'h0;
		end else begin
			if (pair_we) begin
				isel_r <= wdata[`DTF_PC_ISEL]; // RQ18
				uflt_r <= wdata[`DTF_PC_UFLT];
				lflt_r <= wdata[`DTF_PC_LFLT];
			end
			if (wsel_drop_w) begin
				wsel_r <= 1'b0;
			end else if (pair_we) begin
				wsel_r <= wdata[`DTF_PC_WSEL]; // RQ18
			end
		end
	end

	// In 16-bit mode one measurement spans both halves
	wire logic mv_hi_w = wsel_r ? meas_valid_lo : meas_valid_hi;
	wire logic mc_hi_w = wsel_r ? meas_cycle_lo : meas_cycle_hi;
	wire logic clr_bf_lo = wsel_r ? rd_dr_hi : rd_dr_lo; // RQ2 RQ6
	wire logic clr_if_lo = wr_csc_lo && !wdata[`DTF_CSC_IF]; // RQ10
	wire logic clr_if_hi = wr_csc_hi && !wdata[`DTF_CSC_IF]; // RQ10
	wire logic undef_hi = wsel_r &&
		((func_lo_r == dtf_pkg::DTF_F_PWM_VAR) ||
		dtf_pkg::dtf_is_cap(func_lo_r)); // RQ20

	dtf_chan u_lo (
		.hclk(hclk),
		.hresetn(hresetn),
		.func(func_lo_r),
		.run(run_lo_r),
		.run_rise(run_lo_rise),
		.hold_zero(1'b0),
		.out_undef(1'b0),
		.so_eff(so_lo_r),
		.meas_valid(meas_valid_lo),
		.meas_cycle(meas_cycle_lo),
		.meas_count(meas_count_lo),
		.match(match_lo),
		.ovf(ovf_lo),
		.fn_out(fn_out_lo),
		.dr_read(clr_bf_lo),
		.dr_wr(wr_dr_lo),
		.if_clr(clr_if_lo),
		.wdata(wdata),
		.bf(bf_lo),
		.iflag(if_lo),
		.out_state(out_lo),
		.dr(dr_lo)
	);

	// Upper half follows the lower function when joined
	dtf_chan u_hi (
		.hclk(hclk),
		.hresetn(hresetn),
		.func(wsel_r ? func_lo_r : func_hi_r),
		.run(run_hi_r),
		.run_rise(run_hi_rise),
		.hold_zero(wsel_r), // RQ6 RQ12
		.out_undef(undef_hi),
		.so_eff(wsel_r ? so_lo_r : so_hi_r), // RQ14
		.meas_valid(mv_hi_w),
		.meas_cycle(mc_hi_w),
		.meas_count(meas_count_hi),
		.match(match_hi),
		.ovf(ovf_hi),
		.fn_out(fn_out_hi),
		.dr_read(rd_dr_hi && !wsel_r),
		.dr_wr(wr_dr_hi),
		.if_clr(clr_if_hi),
		.wdata(wdata),
		.bf(bf_hi),
		.iflag(if_hi),
		.out_state(out_hi),
		.dr(dr_hi)
	);

	// Status words; the alias offsets return the reload flag as one
	wire logic [7:0] csc_lo_w = {run_lo_r, susp_lo_r, ie_lo_r, 1'b0,
		bf_lo, if_lo, so_lo_r, oe_lo_r};
	wire logic [7:0] csc_hi_w = {run_hi_r, susp_hi_r, ie_hi_r, 1'b0,
		bf_hi, if_hi, so_hi_r, oe_hi_r};
	wire logic [7:0] pair_w = {out_hi, out_lo, isel_r && CHAN_ZERO,
		wsel_r, uflt_r, lflt_r}; // RQ18 RQ19
	wire logic [7:0] rmw_mask_w = 8'h04;

	always_comb begin
		unique case (reg_addr)
			`DTF_OFF_CSC_LO: rdata = csc_lo_w;
			`DTF_OFF_CSC_HI: rdata = csc_hi_w;
			`DTF_OFF_FN_LO: rdata = {3'h0, rig_lo_r, func_lo_r};
			`DTF_OFF_FN_HI: rdata = {3'h0, rig_hi_r, func_hi_r};
			`DTF_OFF_PAIR: rdata = pair_w;
			`DTF_OFF_DR_LO: rdata = dr_lo;
			`DTF_OFF_DR_HI: rdata = dr_hi;
			`DTF_OFF_RMW_LO: rdata = csc_lo_w | rmw_mask_w; // RQ10 RQ26
			`DTF_OFF_RMW_HI: rdata = csc_hi_w | rmw_mask_w; // RQ10 RQ26
			default: rdata = 8'h00;
		endcase
	end

	assign run_lo = run_lo_r;
	assign run_hi = run_hi_r;
	assign susp_lo = susp_lo_r;
	assign susp_hi = susp_hi_r;
	assign func_lo = func_lo_r;
	assign func_hi = func_hi_r;
	assign width_sel = wsel_r;
	assign input_source_sel = isel_r;
	assign upper_noise_filter_sel = uflt_r;
	assign lower_noise_filter_sel = lflt_r;
	assign lower_data_reg = dr_lo;
	assign upper_data_reg = dr_hi;

	// Port logic takes the pin whenever the enable is clear
	assign pin_lo_o = out_lo;
	assign pin_lo_oe = oe_lo_r; // RQ17
	assign pin_hi_o = out_hi;
	assign pin_hi_oe = oe_hi_r; // RQ17

	assign irq_lo = ie_lo_r && rig_lo_r && if_lo; // RQ25
	assign irq_hi = ie_hi_r && rig_hi_r && if_hi; // RQ25
endmodule : dtf_top

// *** verification/dtf_top_assertions.sv ***
// Port-level checks on the dual timer flag block.
// Assumes a single AHB slave, so hready equals hreadyout.
`timescale 1ns/1ps
`include "dtf_map.svh"
module dtf_top_assertions (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic meas_valid_lo,
	input wire logic meas_cycle_lo,
	input wire logic [7:0] meas_count_lo,
	input wire logic run_lo,
	input wire logic run_hi,
	input wire logic [3:0] func_lo,
	input wire logic width_sel,
	input wire logic [7:0] lower_data_reg,
	input wire logic pin_lo_o,
	input wire logic pin_hi_o,
	input wire logic irq_lo,
	input wire logic irq_hi
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Shadow of the lower full flag, rebuilt from bus and event traffic
	logic full_r, full_nxt, dr_rd_r, dr_rd_nxt;
	logic pwc_lo, store_lo, hi_undef, dr_hit;
	assign pwc_lo = (func_lo >= 4'h5) && (func_lo <= 4'h9);
	assign dr_hit = haddr[7:0] == (width_sel ? `DTF_OFF_DR_HI : `DTF_OFF_DR_LO);
	assign dr_rd_nxt = hsel && htrans[1] && hready && !hwrite && dr_hit;
	assign store_lo = meas_valid_lo && pwc_lo
		&& (!full_r || (func_lo == 4'h9 && !meas_cycle_lo));
	// Set wins over a clear landing in the same cycle
	assign full_nxt = !pwc_lo ? 1'h0 : store_lo ? 1'h1 : dr_rd_r ? 1'h0 : full_r;
	assign hi_undef = width_sel && (func_lo == 4'h4 || func_lo >= 4'ha);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			full_r <= 1'h0;
			dr_rd_r <= 1'h0;
		end else begin
			full_r <= full_nxt;
			dr_rd_r <= dr_rd_nxt;
		end
	end
	sequence s_undef;
		hi_undef [*2];
	endsequence
	sequence s_quiet;
		!run_lo && !$past(run_lo) && !$past(run_lo, 2)
			&& func_lo == $past(func_lo, 2);
	endsequence
	property p_store;
		store_lo |=> lower_data_reg == $past(meas_count_lo);
	endproperty
	a_store: assert property (p_store) else $error("result not stored");
	property p_hold;
		meas_valid_lo && pwc_lo && !store_lo |=> $stable(lower_data_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("full data overwritten");
	property p_pwm_if;
		func_lo == 4'h4 && $past(func_lo) == 4'h4 |-> !irq_lo;
	endproperty
	a_pwm_if: assert property (p_pwm_if) else $error("reload irq in pwm");
	property p_hi_if;
		width_sel && $past(width_sel) |-> !irq_hi;
	endproperty
	a_hi_if: assert property (p_hi_if) else $error("upper irq in 16-bit");
	property p_start;
		$rose(run_lo) && func_lo == 4'h4 |-> ##[0:1] run_hi;
	endproperty
	a_start: assert property (p_start) else $error("upper did not start");
	property p_stop;
		$fell(run_lo) && (func_lo == 4'h4 || width_sel) |-> ##[0:1] !run_hi;
	endproperty
	a_stop: assert property (p_stop) else $error("upper did not stop");
	property p_undef;
		s_undef |-> !pin_hi_o;
	endproperty
	a_undef: assert property (p_undef) else $error("undefined state shown");
	property p_retain;
		s_quiet |-> $stable(pin_lo_o);
	endproperty
	a_retain: assert property (p_retain) else $error("stopped output moved");
endmodule : dtf_top_assertions

bind dtf_top dtf_top_assertions dtf_top_assertions_i (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.meas_valid_lo, .meas_cycle_lo, .meas_count_lo, .run_lo, .run_hi,
	.func_lo, .width_sel, .lower_data_reg, .pin_lo_o, .pin_hi_o,
	.irq_lo, .irq_hi
);

// *** verification/dtf_far_model.sv ***
// Far side of one timer channel: measurement, match and overflow events,
// the function output level and the pin line with its pull-down.
// Assumes callers enter the tasks just after a rising edge.
`timescale 1ns/1ps
module dtf_far_model (
	input wire logic hclk,
	input wire logic pin_o,
	input wire logic pin_oe,
	output logic pin_lvl,
	output logic meas_valid,
	output logic meas_cycle,
	output logic [7:0] meas_count,
	output logic match,
	output logic ovf,
	output logic fn_out
);
	// Released line falls to the pull-down level
	assign pin_lvl = pin_oe ? pin_o : 1'h0;
	initial begin
		meas_valid = 1'h0;
		meas_cycle = 1'h0;
		meas_count = 8'h5a;
		match = 1'h0;
		ovf = 1'h0;
		fn_out = 1'h0;
	end
	task automatic measure(input logic cyc, input logic [7:0] cnt);
		meas_cycle <= cyc;
		meas_count <= cnt;
		meas_valid <= 1'h1;
		@(posedge hclk);
		meas_valid <= 1'h0;
		// Stale count is scrambled so it never passes for a result
		meas_count <= ~cnt;
		@(posedge hclk);
	endtask : measure
	task automatic pulse(input logic is_ovf);
		match <= !is_ovf;
		ovf <= is_ovf;
		@(posedge hclk);
		match <= 1'h0;
		ovf <= 1'h0;
		@(posedge hclk);
	endtask : pulse
	task automatic set_out(input logic v);
		fn_out <= v;
	endtask : set_out
endmodule : dtf_far_model

// *** verification/tb_top.sv ***
// Self-checking bench for the dual timer flag block on AHB-Lite.
// Assumes two far-side models feed the datapath events.
`timescale 1ns/1ps
`include "dtf_map.svh"
module tb_top;
	localparam logic [7:0] CL = `DTF_OFF_CSC_LO;
	localparam logic [7:0] CH = `DTF_OFF_CSC_HI;
	localparam logic [7:0] FL = `DTF_OFF_FN_LO;
	localparam logic [7:0] PC = `DTF_OFF_PAIR;
	localparam logic [7:0] DL = `DTF_OFF_DR_LO;
	localparam logic [7:0] DH = `DTF_OFF_DR_HI;
	localparam logic [7:0] RL = `DTF_OFF_RMW_LO;
	localparam logic [7:0] RST_A [8] = '{CL, CH, FL, `DTF_OFF_FN_HI, PC, DL,
		DH, 8'h24};
	logic hclk, hresetn, hsel, hwrite, hreadyout;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic meas_valid_lo, meas_valid_hi, meas_cycle_lo, meas_cycle_hi;
	logic match_lo, match_hi, ovf_lo, ovf_hi, fn_out_lo, fn_out_hi;
	logic [7:0] meas_count_lo, meas_count_hi, a, b, c, d;
	logic pin_lo_o, pin_lo_oe, pin_hi_o, pin_hi_oe, irq_lo, lvl_lo;
	int fails = 0;
	int n_tests = 0;
	logic [31:0] exp_q[$];
	string nm_q[$];
	logic rd_ph = 1'h0;
	dtf_top dtf_top_i (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hreadyout, .hresp(), .hrdata,
		.meas_valid_lo, .meas_valid_hi, .meas_cycle_lo, .meas_cycle_hi,
		.meas_count_lo, .meas_count_hi, .match_lo, .match_hi,
		.ovf_lo, .ovf_hi, .fn_out_lo, .fn_out_hi,
		.run_lo(), .run_hi(), .susp_lo(), .susp_hi(), .func_lo(),
		.func_hi(), .width_sel(), .input_source_sel(),
		.upper_noise_filter_sel(), .lower_noise_filter_sel(),
		.lower_data_reg(), .upper_data_reg(), .pin_lo_o, .pin_lo_oe,
		.pin_hi_o, .pin_hi_oe, .irq_lo, .irq_hi()
	);
	dtf_far_model far_lo (
		.hclk, .pin_o(pin_lo_o), .pin_oe(pin_lo_oe), .pin_lvl(lvl_lo),
		.meas_valid(meas_valid_lo), .meas_cycle(meas_cycle_lo),
		.meas_count(meas_count_lo), .match(match_lo), .ovf(ovf_lo),
		.fn_out(fn_out_lo)
	);
	dtf_far_model far_hi (
		.hclk, .pin_o(pin_hi_o), .pin_oe(pin_hi_oe), .pin_lvl(),
		.meas_valid(meas_valid_hi), .meas_cycle(meas_cycle_hi),
		.meas_count(meas_count_hi), .match(match_hi), .ovf(ovf_hi),
		.fn_out(fn_out_hi)
	);
	task automatic wrap_up;
		if (fails == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	task automatic cmp_word(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp_word
	task automatic cmp_pin(input string nm, input logic e, input logic s);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %b seen %b", nm, e, s);
		end
	endtask : cmp_pin
	task automatic xfer(input logic w, input logic [7:0] ad,
		input logic [7:0] dt);
		hsel <= 1'h1;
		haddr <= {24'h0, ad};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= {24'h0, dt};
		do @(posedge hclk); while (hreadyout !== 1'h1);
	endtask : xfer
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		xfer(1'h1, ad, dt);
	endtask : wr
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		nm_q.push_back($sformatf("reg %h", ad));
		xfer(1'h0, ad, 8'h00);
	endtask : rd
	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end
	// Read data counts at the edge that ends the data phase
	initial begin : mon
		logic [31:0] e;
		forever begin
			@(posedge hclk);
			if (exp_q.size() > 0 && rd_ph === 1'h1 && hreadyout === 1'h1) begin
				e = exp_q.pop_front();
				cmp_word(nm_q.pop_front(), e, hrdata);
			end
			if (hsel && htrans[1] && hreadyout && !hwrite) rd_ph = 1'h1;
			else if (hreadyout) rd_ph = 1'h0;
		end
	end
	initial begin
		repeat (5000) @(posedge hclk);
		fails++;
		wrap_up();
	end
	initial begin
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		void'($urandom(14));
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		foreach (RST_A[i]) rd(RST_A[i], 32'h0);
		wr(PC, 8'h3f);
		rd(PC, 32'h3f);
		wr(PC, 8'h00);
		a = 8'($urandom());
		c = ~a;
		b = a ^ 8'h3c;
		d = 8'($urandom());
		wr(FL, 8'h05);
		wr(CL, 8'h80);
		far_lo.measure(1'h0, a);
		rd(CL, 32'h88);
		far_lo.measure(1'h0, b);
		rd(DL, {24'h0, a});
		rd(CL, 32'h80);
		wr(CL, 8'h88);
		rd(CL, 32'h80);
		far_lo.pulse(1'h1);
		rd(CL, 32'h84);
		wr(CL, 8'ha4);
		rd(RL, 32'ha4);
		wr(FL, 8'h19);
		rd(FL, 32'h15);
		cmp_pin("irq_lo", 1'h1, irq_lo);
		wr(CL, 8'ha0);
		rd(CL, 32'ha0);
		rd(RL, 32'ha4);
		cmp_pin("irq_lo", 1'h0, irq_lo);
		wr(CL, 8'h00);
		wr(FL, 8'h09);
		wr(CL, 8'h80);
		far_lo.measure(1'h0, a);
		far_lo.measure(1'h1, b);
		far_lo.measure(1'h0, c);
		rd(DL, {24'h0, c});
		far_lo.measure(1'h1, d);
		rd(DL, {24'h0, d});
		wr(CL, 8'h00);
		wr(FL, 8'h00);
		wr(CL, 8'h80);
		far_lo.pulse(1'h0);
		rd(CL, 32'h84);
		wr(CL, 8'h00);
		wr(FL, 8'h04);
		far_lo.pulse(1'h0);
		rd(CL, 32'h00);
		wr(CL, 8'h80);
		rd(CH, 32'h80);
		wr(CH, 8'h00);
		rd(CL, 32'h00);
		wr(FL, 8'h00);
		far_lo.set_out(1'h1);
		wr(CL, 8'h83);
		wr(CL, 8'h01);
		far_lo.set_out(1'h0);
		rd(PC, 32'h40);
		cmp_pin("pin_lo", 1'h1, lvl_lo);
		wr(FL, 8'h01);
		rd(PC, 32'h00);
		wr(FL, 8'h00);
		wr(CL, 8'h00);
		rd(PC, 32'h40);
		cmp_pin("pin_lo_oe", 1'h0, pin_lo_oe);
		cmp_pin("pin_lo", 1'h0, lvl_lo);
		wr(PC, 8'h10);
		wr(FL, 8'h04);
		wr(FL, 8'h05);
		wr(CL, 8'h80);
		wr(CH, 8'h82);
		wr(CL, 8'h82);
		rd(CL, 32'h80);
		rd(CH, 32'h82);
		fork
			far_lo.measure(1'h0, a);
			far_hi.measure(1'h1, b);
		join
		far_hi.pulse(1'h0);
		far_hi.pulse(1'h1);
		rd(CH, 32'h82);
		rd(DL, {24'h0, a});
		rd(CL, 32'h88);
		rd(DH, {24'h0, b});
		rd(CL, 32'h80);
		repeat (4) @(posedge hclk);
		wrap_up();
	end
endmodule : tb_top
